// >>> spcb_bank.sv
`timescale 1ns/100ps
`include "spcb_defines.svh"

//Contract
//RULE1: bit 7 routes reads to output pin
//RULE2: bit 6 low: msb first, address down
//RULE3: bit 6 high: lsb first, address up
//RULE4: bit 5 soft reset, self clearing
//RULE5: host mirrors low nibble of config
//RULE6: i2c mode: bits 7:6 reserved
//RULE7: readback select 0 reads active values
//RULE8: readback select 1 reads pending values
//RULE9: version id low byte, default zero
//RULE10: version id high byte, default zero
//RULE11: io update copies pending to active
//RULE12: nvm registers reset zero, status read-only
module spcb_bank
  import spcb_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic i2c_mode_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire spcb_addr_t addr_i,
  input wire spcb_byte_t wr_data_i,
  input wire logic io_update_i,
  input wire logic nvm_busy_i,
  input wire logic nvm_data_error_i,
  output spcb_byte_t rd_data_o,
  output logic rd_valid_o,
  output logic output_pin_direction_select_o,
  output logic lsb_first_o,
  output logic addr_increment_o,
  output logic soft_reset_o,
  output logic [15:0] customer_version_o,
  output spcb_byte_t end_marker_o,
  output logic nvm_write_enable_o,
  output logic nvm_soft_load_o,
  output logic registers_to_nvm_copy_o
);

  localparam int VER_BYTES = 2;
  localparam spcb_byte_t RST_CONFIG = `SPCB_RST_CONFIG;
  localparam spcb_byte_t RST_READBACK = `SPCB_RST_READBACK;
  localparam spcb_byte_t RST_NVM = `SPCB_RST_NVM;
  localparam spcb_addr_t VER_ADDR [VER_BYTES] = '{`SPCB_OFS_VER_LOW, `SPCB_OFS_VER_HIGH};

  // shared write decode
  logic wr_cfg;
  logic soft_req;

  assign wr_cfg = wr_en_i && (addr_i == `SPCB_OFS_CONFIG);
  assign soft_req = wr_cfg && wr_data_i[`SPCB_CFG_SRST_BIT]; // RULE4

  // serial port configuration
  logic dir_ff, nxt_dir;
  logic lsb_ff, nxt_lsb;
  logic [1:0] mirror_ff, nxt_mirror;
  logic srst_ff, nxt_srst;

  always_comb begin
    nxt_dir = dir_ff;
    nxt_lsb = lsb_ff;
    nxt_mirror = mirror_ff;
    nxt_srst = soft_req; // RULE4
    if (soft_req) begin
      // reset wins over the other fields of the same byte
      nxt_dir = RST_CONFIG[`SPCB_CFG_DIR_BIT]; // RULE4
      nxt_lsb = RST_CONFIG[`SPCB_CFG_LSB_BIT];
      nxt_mirror = {RST_CONFIG[`SPCB_CFG_MIRROR_LSB_BIT],
                    RST_CONFIG[`SPCB_CFG_MIRROR_DIR_BIT]};
    end else if (wr_cfg && !i2c_mode_i) begin // RULE6
      // top bits reserved under i2c, writes there are dropped
      nxt_dir = wr_data_i[`SPCB_CFG_DIR_BIT]; // RULE1
      nxt_lsb = wr_data_i[`SPCB_CFG_LSB_BIT]; // RULE2 RULE3
      nxt_mirror = {wr_data_i[`SPCB_CFG_MIRROR_LSB_BIT],
                    wr_data_i[`SPCB_CFG_MIRROR_DIR_BIT]}; // RULE5
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      dir_ff <= RST_CONFIG[`SPCB_CFG_DIR_BIT];
      lsb_ff <= RST_CONFIG[`SPCB_CFG_LSB_BIT];
      mirror_ff <= {RST_CONFIG[`SPCB_CFG_MIRROR_LSB_BIT],
                    RST_CONFIG[`SPCB_CFG_MIRROR_DIR_BIT]};
      srst_ff <= 1'b0;
    end else begin
      dir_ff <= nxt_dir;
      lsb_ff <= nxt_lsb;
      mirror_ff <= nxt_mirror;
      srst_ff <= nxt_srst;
    end
  end

  // readback source select and end marker
  logic rb_pending_ff, nxt_rb_pending;
  spcb_byte_t end_marker_ff, nxt_end_marker;

  always_comb begin
    nxt_rb_pending = rb_pending_ff;
    nxt_end_marker = end_marker_ff;
    if (soft_req) begin
      nxt_rb_pending = RST_READBACK[`SPCB_RB_PENDING_BIT]; // RULE4
      nxt_end_marker = `SPCB_RST_END_MARKER;
    end else if (wr_en_i) begin
      case (addr_i)
        `SPCB_OFS_READBACK: begin
          nxt_rb_pending = wr_data_i[`SPCB_RB_PENDING_BIT]; // RULE7 RULE8
        end
        `SPCB_OFS_END_MARKER: begin
          nxt_end_marker = wr_data_i;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      rb_pending_ff <= RST_READBACK[`SPCB_RB_PENDING_BIT];
      end_marker_ff <= `SPCB_RST_END_MARKER;
    end else begin
      rb_pending_ff <= nxt_rb_pending;
      end_marker_ff <= nxt_end_marker;
    end
  end

  // nvm control and status
  logic nvm_status_ff, nxt_nvm_status;
  logic nvm_error_ff, nxt_nvm_error;
  logic nvm_wren_ff, nxt_nvm_wren;
  logic nvm_soft_ff, nxt_nvm_soft;
  logic nvm_copy_ff, nxt_nvm_copy;

  always_comb begin
    nxt_nvm_wren = nvm_wren_ff;
    nxt_nvm_soft = nvm_soft_ff;
    nxt_nvm_copy = nvm_copy_ff;
    // status bits follow the nvm engine, host writes reach them only through soft reset
    nxt_nvm_status = nvm_busy_i; // RULE12
    nxt_nvm_error = nvm_data_error_i; // RULE12
    if (soft_req) begin
      nxt_nvm_wren = RST_NVM[`SPCB_NVM_WREN_BIT]; // RULE4
      nxt_nvm_soft = RST_NVM[`SPCB_NVM_SOFT_BIT];
      nxt_nvm_copy = RST_NVM[`SPCB_NVM_COPY_BIT];
      nxt_nvm_status = RST_NVM[`SPCB_NVM_STATUS_BIT];
      nxt_nvm_error = RST_NVM[`SPCB_NVM_ERROR_BIT];
    end else if (wr_en_i) begin
      case (addr_i)
        `SPCB_OFS_NVM_CTRL1: begin
          nxt_nvm_wren = wr_data_i[`SPCB_NVM_WREN_BIT];
          nxt_nvm_soft = wr_data_i[`SPCB_NVM_SOFT_BIT];
        end
        `SPCB_OFS_NVM_CTRL2: begin
          nxt_nvm_copy = wr_data_i[`SPCB_NVM_COPY_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      nvm_status_ff <= RST_NVM[`SPCB_NVM_STATUS_BIT]; // RULE12
      nvm_error_ff <= RST_NVM[`SPCB_NVM_ERROR_BIT];
      nvm_wren_ff <= RST_NVM[`SPCB_NVM_WREN_BIT];
      nvm_soft_ff <= RST_NVM[`SPCB_NVM_SOFT_BIT];
      nvm_copy_ff <= RST_NVM[`SPCB_NVM_COPY_BIT];
    end else begin
      nvm_status_ff <= nxt_nvm_status;
      nvm_error_ff <= nxt_nvm_error;
      nvm_wren_ff <= nxt_nvm_wren;
      nvm_soft_ff <= nxt_nvm_soft;
      nvm_copy_ff <= nxt_nvm_copy;
    end
  end

  // buffered version bytes, pending and active copy per byte
  spcb_byte_t ver_pend [VER_BYTES];
  spcb_byte_t ver_act [VER_BYTES];

  for (genvar g = 0; g < VER_BYTES; g++) begin : g_ver
    spcb_byte_t pend_ff, nxt_pend;
    spcb_byte_t act_ff, nxt_act;

    always_comb begin
      nxt_pend = pend_ff;
      nxt_act = act_ff;
      if (soft_req) begin
        nxt_pend = `SPCB_RST_VER; // RULE4
        nxt_act = `SPCB_RST_VER;
      end else begin
        // update takes the pending value from before a same-cycle write
        if (io_update_i) begin
          nxt_act = pend_ff; // RULE11
        end
        if (wr_en_i && (addr_i == VER_ADDR[g])) begin
          nxt_pend = wr_data_i; // RULE9 RULE10
        end
      end
    end

    always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
        pend_ff <= `SPCB_RST_VER; // RULE9 RULE10
        act_ff <= `SPCB_RST_VER;
      end else begin
        pend_ff <= nxt_pend;
        act_ff <= nxt_act;
      end
    end

    assign ver_pend[g] = pend_ff;
    assign ver_act[g] = act_ff;
  end

  // mode outputs, masked while the port runs i2c
  logic dir_out_ff, nxt_dir_out;
  logic lsb_out_ff, nxt_lsb_out;

  always_comb begin
    nxt_dir_out = dir_ff && !i2c_mode_i; // RULE1
    nxt_lsb_out = lsb_ff && !i2c_mode_i; // RULE2 RULE3
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      dir_out_ff <= 1'b0;
      lsb_out_ff <= 1'b0;
    end else begin
      dir_out_ff <= nxt_dir_out;
      lsb_out_ff <= nxt_lsb_out;
    end
  end

  // registered read path
  spcb_byte_t rd_data_ff, nxt_rd_data;
  logic rd_valid_ff, nxt_rd_valid;

  always_comb begin
    nxt_rd_valid = rd_en_i;
    nxt_rd_data = rd_data_ff;
    if (rd_en_i) begin
      case (addr_i)
        `SPCB_OFS_CONFIG: begin
          if (i2c_mode_i) begin
            nxt_rd_data = 8'h00; // RULE6
          end else begin
            nxt_rd_data = {dir_ff, lsb_ff, 4'h0, mirror_ff};
          end
        end
        `SPCB_OFS_READBACK: begin
          nxt_rd_data = {7'h00, rb_pending_ff};
        end
        `SPCB_OFS_VER_LOW: begin
          nxt_rd_data = rb_pending_ff ? ver_pend[0] : ver_act[0]; // RULE7 RULE8
        end
        `SPCB_OFS_VER_HIGH: begin
          nxt_rd_data = rb_pending_ff ? ver_pend[1] : ver_act[1]; // RULE7 RULE8
        end
        `SPCB_OFS_END_MARKER: begin
          nxt_rd_data = end_marker_ff;
        end
        `SPCB_OFS_NVM_STATUS: begin
          nxt_rd_data = {7'h00, nvm_status_ff}; // RULE12
        end
        `SPCB_OFS_NVM_ERROR: begin
          nxt_rd_data = {7'h00, nvm_error_ff}; // RULE12
        end
        `SPCB_OFS_NVM_CTRL1: begin
          nxt_rd_data = {6'h00, nvm_soft_ff, nvm_wren_ff};
        end
        `SPCB_OFS_NVM_CTRL2: begin
          nxt_rd_data = {7'h00, nvm_copy_ff};
        end
        default: begin
          nxt_rd_data = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      rd_data_ff <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
    end
  end

  assign rd_data_o = rd_data_ff;
  assign rd_valid_o = rd_valid_ff;
  assign output_pin_direction_select_o = dir_out_ff; // RULE1
  assign lsb_first_o = lsb_out_ff; // RULE3
  assign addr_increment_o = lsb_out_ff; // RULE2 RULE3
  assign soft_reset_o = srst_ff; // RULE4
  assign customer_version_o = {ver_act[1], ver_act[0]};
  assign end_marker_o = end_marker_ff;
  assign nvm_write_enable_o = nvm_wren_ff;
  assign nvm_soft_load_o = nvm_soft_ff;
  assign registers_to_nvm_copy_o = nvm_copy_ff;

endmodule // spcb_bank

// >>> spcb_checker.sv
`timescale 1ns/100ps
`include "spcb_defines.svh"
module spcb_checker
  import spcb_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic i2c_mode_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire spcb_addr_t addr_i,
  input wire spcb_byte_t wr_data_i,
  input wire logic io_update_i,
  input wire spcb_byte_t rd_data_o,
  input wire logic output_pin_direction_select_o,
  input wire logic lsb_first_o,
  input wire logic addr_increment_o,
  input wire logic soft_reset_o,
  input wire logic [15:0] customer_version_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);
  property p_dir; i2c_mode_i |=> !output_pin_direction_select_o; endproperty
  a_dir: assert property (p_dir) else $error("dir set in i2c");
  property p_lsb; i2c_mode_i |=> !lsb_first_o; endproperty
  a_lsb: assert property (p_lsb) else $error("lsb set in i2c");
  property p_inc; addr_increment_o == lsb_first_o; endproperty
  a_inc: assert property (p_inc) else $error("step vs order");
  property p_srst;
    wr_en_i && addr_i == `SPCB_OFS_CONFIG && wr_data_i[`SPCB_CFG_SRST_BIT] |=> soft_reset_o;
  endproperty
  a_srst: assert property (p_srst) else $error("no soft reset");
  property p_step;
    wr_en_i && addr_i == `SPCB_OFS_CONFIG && !i2c_mode_i && !wr_data_i[`SPCB_CFG_SRST_BIT]
      ##1 !i2c_mode_i |=> addr_increment_o == $past(wr_data_i[`SPCB_CFG_LSB_BIT], 2);
  endproperty
  a_step: assert property (p_step) else $error("step not from order bit");
  property p_sdef; soft_reset_o |-> customer_version_o == 16'h0000; endproperty
  a_sdef: assert property (p_sdef) else $error("id kept");
  property p_ver; !$stable(customer_version_o) |-> $past(io_update_i) || soft_reset_o; endproperty
  a_ver: assert property (p_ver) else $error("id moved");
  property p_sts; rd_en_i && addr_i == `SPCB_OFS_NVM_STATUS |=> rd_data_o[7:1] == 7'h00; endproperty
  a_sts: assert property (p_sts) else $error("status bits");
  property p_i2c;
    rd_en_i && i2c_mode_i && addr_i == `SPCB_OFS_CONFIG |=> rd_data_o == 8'h00;
  endproperty
  a_i2c: assert property (p_i2c) else $error("cfg in i2c");
  c_srst: cover property (soft_reset_o);
  c_upd: cover property (io_update_i);
  c_dir: cover property (output_pin_direction_select_o);
endmodule // spcb_checker
bind spcb_bank spcb_checker chk (.core_clk_i, .rstn_i, .i2c_mode_i, .wr_en_i, .rd_en_i,
  .addr_i, .wr_data_i, .io_update_i, .rd_data_o, .output_pin_direction_select_o,
  .lsb_first_o, .addr_increment_o, .soft_reset_o, .customer_version_o);

// >>> spcb_defines.svh
`ifndef SPCB_DEFINES_SVH
`define SPCB_DEFINES_SVH

`define SPCB_ADDR_W 12
`define SPCB_DATA_W 8

`define SPCB_OFS_CONFIG 12'h000
`define SPCB_OFS_READBACK 12'h004
`define SPCB_OFS_VER_LOW 12'h005
`define SPCB_OFS_VER_HIGH 12'h006
`define SPCB_OFS_END_MARKER 12'hA16
`define SPCB_OFS_NVM_STATUS 12'hB00
`define SPCB_OFS_NVM_ERROR 12'hB01
`define SPCB_OFS_NVM_CTRL1 12'hB02
`define SPCB_OFS_NVM_CTRL2 12'hB03

`define SPCB_CFG_DIR_BIT 7
`define SPCB_CFG_LSB_BIT 6
`define SPCB_CFG_SRST_BIT 5
`define SPCB_CFG_MIRROR_DIR_BIT 0
`define SPCB_CFG_MIRROR_LSB_BIT 1
`define SPCB_RB_PENDING_BIT 0
`define SPCB_NVM_STATUS_BIT 0
`define SPCB_NVM_ERROR_BIT 0
`define SPCB_NVM_WREN_BIT 0
`define SPCB_NVM_SOFT_BIT 1
`define SPCB_NVM_COPY_BIT 0

`define SPCB_RST_CONFIG 8'h00
`define SPCB_RST_READBACK 8'h00
`define SPCB_RST_VER 8'h00
`define SPCB_RST_END_MARKER 8'hFF
`define SPCB_RST_NVM 8'h00

`endif

// >>> spcb_host_model.sv
`timescale 1ns/100ps
`include "spcb_defines.svh"
module spcb_host_model
  import spcb_pkg::*;
(
  input wire logic core_clk_i,
  input wire spcb_byte_t rd_data_i,
  input wire logic rd_valid_i,
  output logic wr_en_o,
  output logic rd_en_o,
  output spcb_addr_t addr_o,
  output spcb_byte_t wr_data_o
);
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 12'h000;
    wr_data_o = 8'h00;
  end
  // idle bus shows the inverted address, and the inverted data only after a write
  task automatic wr(input spcb_addr_t a, input spcb_byte_t d);
    @(negedge core_clk_i);
    {addr_o, wr_data_o, wr_en_o} = {a, d, 1'b1};
    @(negedge core_clk_i);
    {addr_o, wr_data_o, wr_en_o} = {~a, ~d, 1'b0};
  endtask
  task automatic rd(input spcb_addr_t a, output spcb_byte_t d, output logic v);
    @(negedge core_clk_i);
    {addr_o, rd_en_o} = {a, 1'b1};
    @(negedge core_clk_i);
    {addr_o, rd_en_o} = {~a, 1'b0};
    d = rd_data_i;
    v = rd_valid_i;
  endtask
  task automatic cfg(input logic [3:0] h);
    wr(`SPCB_OFS_CONFIG, {h, h[0], h[1], h[2], h[3]});
  endtask
endmodule // spcb_host_model

// >>> spcb_pkg.sv
`include "spcb_defines.svh"

package spcb_pkg;
  typedef logic [`SPCB_ADDR_W-1:0] spcb_addr_t;
  typedef logic [`SPCB_DATA_W-1:0] spcb_byte_t;
endpackage

// >>> testbench.sv
`timescale 1ns/100ps
`include "spcb_defines.svh"
module testbench;
  import spcb_pkg::*;
  logic core_clk_i, rstn_i, i2c_mode_i, io_update_i, nvm_busy_i, nvm_data_error_i;
  logic wr_en_i, rd_en_i, rd_valid_o, output_pin_direction_select_o, lsb_first_o;
  logic addr_increment_o, soft_reset_o, nvm_write_enable_o, nvm_soft_load_o;
  logic registers_to_nvm_copy_o, v;
  spcb_addr_t addr_i;
  spcb_byte_t wr_data_i, rd_data_o, end_marker_o, d, lo, hi;
  logic [15:0] customer_version_o, ever;
  int miscompares = 0;
  int n_tests = 0;
  spcb_bank dut (.core_clk_i, .rstn_i, .i2c_mode_i, .wr_en_i, .rd_en_i, .addr_i, .wr_data_i,
    .io_update_i, .nvm_busy_i, .nvm_data_error_i, .rd_data_o, .rd_valid_o,
    .output_pin_direction_select_o, .lsb_first_o, .addr_increment_o, .soft_reset_o,
    .customer_version_o, .end_marker_o, .nvm_write_enable_o, .nvm_soft_load_o,
    .registers_to_nvm_copy_o);
  spcb_host_model host (.core_clk_i, .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o),
    .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .addr_o(addr_i), .wr_data_o(wr_data_i));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  function automatic logic spi_bit(input logic b);
    return b & ~i2c_mode_i;
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input spcb_addr_t a, input spcb_byte_t e);
    host.rd(a, d, v);
    chk("rd_valid_o", 16'h0001, {15'h0000, v});
    chk("rd_data_o", {8'h00, e}, {8'h00, d});
  endtask
  task automatic mode_chk(input logic [1:0] m);
    host.cfg({m, 2'b00});
    repeat (2) @(negedge core_clk_i);
    chk("dir", {15'h0000, spi_bit(m[1])}, {15'h0000, output_pin_direction_select_o});
    chk("lsb", {15'h0000, spi_bit(m[0])}, {15'h0000, lsb_first_o});
    chk("inc", {15'h0000, spi_bit(m[0])}, {15'h0000, addr_increment_o});
    rchk(`SPCB_OFS_CONFIG, i2c_mode_i ? 8'h00 : {m, 4'h0, m[0], m[1]});
  endtask
  task automatic end_of_test;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    end_of_test;
  end
  initial begin
    {rstn_i, i2c_mode_i, io_update_i, nvm_busy_i, nvm_data_error_i} = 5'h00;
    void'($urandom(32'h7E95));
    repeat (5) @(negedge core_clk_i);
    rstn_i = 1'b1;
    for (int i = 0; i < 4; i++) rchk(12'hB00 + 12'(i), 8'h00);
    for (int i = 0; i < 2; i++) begin
      host.wr(12'hB00 + 12'(i), 8'hFF);
      rchk(12'hB00 + 12'(i), 8'h00);
    end
    {nvm_busy_i, nvm_data_error_i} = 2'b11;
    rchk(`SPCB_OFS_NVM_STATUS, 8'h01);
    rchk(`SPCB_OFS_NVM_ERROR, 8'h01);
    host.wr(`SPCB_OFS_NVM_CTRL1, 8'h03);
    host.wr(`SPCB_OFS_NVM_CTRL2, 8'h01);
    d = {5'h00, nvm_write_enable_o, nvm_soft_load_o, registers_to_nvm_copy_o};
    chk("nvm", 16'h0007, {8'h00, d});
    rchk(`SPCB_OFS_NVM_CTRL1, 8'h03);
    rchk(`SPCB_OFS_NVM_CTRL2, 8'h01);
    ever = 16'h0000;
    for (int i = 0; i < 20; i++) begin
      lo = 8'($urandom);
      hi = 8'($urandom);
      host.wr(`SPCB_OFS_VER_LOW, lo);
      host.wr(`SPCB_OFS_VER_HIGH, hi);
      host.wr(`SPCB_OFS_READBACK, 8'h00);
      rchk(`SPCB_OFS_VER_LOW, ever[7:0]);
      host.wr(`SPCB_OFS_READBACK, 8'h01);
      rchk(`SPCB_OFS_VER_HIGH, hi);
      @(negedge core_clk_i) io_update_i = 1'b1;
      @(negedge core_clk_i) io_update_i = 1'b0;
      ever = {hi, lo};
      chk("version", ever, customer_version_o);
    end
    for (int m = 0; m < 4; m++) mode_chk(m[1:0]);
    i2c_mode_i = 1'b1;
    mode_chk(2'b11);
    rchk(`SPCB_OFS_CONFIG, 8'h00);
    for (int k = 1; k >= 0; k--) begin
      i2c_mode_i = k[0];
      host.wr(`SPCB_OFS_END_MARKER, 8'h5A);
      rchk(`SPCB_OFS_END_MARKER, 8'h5A);
      host.cfg(4'h2);
      chk("srst", 16'h0001, {15'h0, soft_reset_o});
      chk("version", 16'h0000, customer_version_o);
      chk("marker", 16'h00FF, {8'h00, end_marker_o});
      rchk(`SPCB_OFS_CONFIG, 8'h00);
      rchk(`SPCB_OFS_READBACK, 8'h00);
      rchk(`SPCB_OFS_NVM_CTRL1, 8'h00);
    end
    end_of_test;
  end
endmodule // testbench
